// >>> logic/ctsf_framer.sv
// Purpose: Frames a compressed table byte stream into private sections
// Assumes: Table bytes arrive already compressed, on the same clock
// Notes:   Sections go out through a two-entry buffer toward the receiver
`timescale 1ns/1ps
`default_nettype none
module ctsf_framer (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_b_i,
	// Table control
	input  wire logic        start_i,
	input  wire logic [18:0] table_len_i,
	input  wire logic [7:0]  seq_num_i,
	input  wire logic        table_change_i,
	// Compressed table bytes
	input  wire logic        tbl_valid_i,
	input  wire logic [7:0]  tbl_data_i,
	output logic             tbl_ready_o,
	// Service signaling channel sections
	output logic             sig_chan_valid_o,
	output logic             sig_chan_first_o,
	output logic             sig_chan_last_o,
	output logic [7:0]       sig_chan_data_o,
	input  wire logic        sig_chan_ready_i,
	// Status
	output logic             busy_o,
	output logic [4:0]       data_version_o
);

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	typedef struct packed {
		ctsf_pkg::ctsf_fsm_t st;
		logic [7:0]          seq;
		logic [4:0]          ver;
		logic [4:0]          ver_snap;
		logic [7:0]          sec;
		logic [7:0]          last_sec;
		logic [18:0]         remain;
		logic [18:0]         in_left;
		logic [10:0]         pay_len;
		logic [10:0]         pay_cnt;
		logic [3:0]          hidx;
		logic                hold_v;
		logic [7:0]          hold;
		logic                in_rdy;
		logic                busy;
	} ctsf_core_st_t;

	ctsf_core_st_t s_q;
	ctsf_core_st_t s_d;
	ctsf_stream_if core_s ();

	logic        push;
	logic        take;
	logic        pay_end;
	logic [11:0] sect_len;
	logic [18:0] len_m1;
	logic [7:0]  hdr_byte;

	assign take     = tbl_valid_i & s_q.in_rdy;
	assign sect_len = ctsf_pkg::HDR_AFTER_LEN + {1'b0, s_q.pay_len};
	assign len_m1   = table_len_i - 19'h00001;
	assign pay_end  = (s_q.pay_cnt == (s_q.pay_len - 11'h001));

	always_comb begin
		case (s_q.hidx)
			ctsf_pkg::HB_TID:    hdr_byte = ctsf_pkg::TABLE_ID;
			ctsf_pkg::HB_LEN_HI: hdr_byte = {ctsf_pkg::SYNTAX_FLAG, ctsf_pkg::PRIVATE_FLAG,
			                                 ctsf_pkg::RSVD_BITS, sect_len[11:8]};
			ctsf_pkg::HB_LEN_LO: hdr_byte = sect_len[7:0];
			ctsf_pkg::HB_PROTO:  hdr_byte = {ctsf_pkg::PROTO_MAJOR, ctsf_pkg::PROTO_MINOR};
			ctsf_pkg::HB_SEQ:    hdr_byte = s_q.seq;
			ctsf_pkg::HB_VER:    hdr_byte = {ctsf_pkg::RSVD_BITS, s_q.ver_snap,
			                                 ctsf_pkg::CUR_NEXT};
			ctsf_pkg::HB_SEC:    hdr_byte = s_q.sec;
			ctsf_pkg::HB_LAST:   hdr_byte = s_q.last_sec;
			ctsf_pkg::HB_SID_HI: hdr_byte = ctsf_pkg::SERVICE_ID[15:8];
			ctsf_pkg::HB_SID_LO: hdr_byte = ctsf_pkg::SERVICE_ID[7:0];
			default:             hdr_byte = ctsf_pkg::TABLE_ID;
		endcase
	end

	always_comb begin
		s_d              = s_q;
		push             = 1'b0;
		core_s.beat      = '0;
		if (table_change_i) begin
			s_d.ver = s_q.ver + 5'h01;
		end
		if (take) begin
			s_d.hold    = tbl_data_i;
			s_d.hold_v  = 1'b1;
			s_d.in_left = s_q.in_left - 19'h00001;
		end
		case (s_q.st)
			ctsf_pkg::ST_IDLE: begin
				// Oversized tables would need more than 256 sections, so they are refused
				if (start_i && (table_len_i != '0) && (table_len_i <= ctsf_pkg::MAX_LEN)) begin
					s_d.st       = ctsf_pkg::ST_HDR;
					s_d.seq      = seq_num_i;
					s_d.ver_snap = s_d.ver;
					s_d.sec      = ctsf_pkg::FIRST_SECTION;
					s_d.last_sec = len_m1[ctsf_pkg::BLK_W+7:ctsf_pkg::BLK_W];
					s_d.remain   = table_len_i;
					s_d.in_left  = table_len_i;
					s_d.pay_len  = (table_len_i > {8'h00, ctsf_pkg::BLOCK_BYTES}) ?
					               ctsf_pkg::BLOCK_BYTES : table_len_i[10:0];
					s_d.hidx     = ctsf_pkg::HB_TID;
				end
			end
			ctsf_pkg::ST_HDR: begin
				if (core_s.ready) begin
					push              = 1'b1;
					core_s.beat.data  = hdr_byte;
					core_s.beat.first = (s_q.hidx == ctsf_pkg::HB_TID);
					if (s_q.hidx == ctsf_pkg::HB_SID_LO) begin
						s_d.st      = ctsf_pkg::ST_PAY;
						s_d.pay_cnt = '0;
					end else begin
						s_d.hidx = s_q.hidx + 4'h1;
					end
				end
			end
			ctsf_pkg::ST_PAY: begin
				if (core_s.ready && s_q.hold_v) begin
					push             = 1'b1;
					core_s.beat.data = s_q.hold;
					core_s.beat.last = pay_end;
					s_d.hold_v       = 1'b0;
					s_d.remain       = s_q.remain - 19'h00001;
					s_d.pay_cnt      = s_q.pay_cnt + 11'h001;
					if (pay_end) begin
						if (s_d.remain == '0) begin
							s_d.st = ctsf_pkg::ST_IDLE;
						end else begin
							s_d.st      = ctsf_pkg::ST_HDR;
							s_d.sec     = s_q.sec + 8'h01;
							s_d.hidx    = ctsf_pkg::HB_TID;
							s_d.pay_len = (s_d.remain > {8'h00, ctsf_pkg::BLOCK_BYTES}) ?
							              ctsf_pkg::BLOCK_BYTES : s_d.remain[10:0];
						end
					end
				end
			end
			default: begin
				s_d.st = ctsf_pkg::ST_IDLE;
			end
		endcase
		// Ready is registered; taking only into an empty hold keeps the pin a flop
		s_d.in_rdy = ~s_d.hold_v && (s_d.st != ctsf_pkg::ST_IDLE) && (s_d.in_left != '0);
		s_d.busy   = (s_d.st != ctsf_pkg::ST_IDLE);
	end

	assign core_s.valid = push;

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tbl_ready_o    = s_q.in_rdy;
	assign busy_o         = s_q.busy;
	assign data_version_o = s_q.ver;

	ctsf_skid_buf u_out_buf (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.in_s      (core_s.snk),
		.valid_o   (sig_chan_valid_o),
		.first_o   (sig_chan_first_o),
		.last_o    (sig_chan_last_o),
		.data_o    (sig_chan_data_o),
		.ready_i   (sig_chan_ready_i)
	);

	logic hdr_push;
	assign hdr_push = push && (s_q.st == ctsf_pkg::ST_HDR);

	a_table_id_byte: assert property (
		hdr_push && s_q.hidx == 4'h0 |-> core_s.beat.data == 8'hec && core_s.beat.first)
		else $error("section does not open with table identifier");

	a_flag_nibble: assert property (
		hdr_push && s_q.hidx == 4'h1 |-> core_s.beat.data[7:4] == 4'h7
		&& {core_s.beat.data[3:0], 8'h00} == sect_len - {4'h0, sect_len[7:0]})
		else $error("flag bits or length high part wrong");

	a_proto_byte: assert property (
		hdr_push && s_q.hidx == 4'h3 |-> core_s.beat.data == 8'h10)
		else $error("protocol version byte wrong");

	a_version_byte: assert property (
		hdr_push && s_q.hidx == 4'h5 |-> core_s.beat.data == {2'b11, s_q.ver_snap, 1'b1})
		else $error("version byte or current flag wrong");

	a_service_zero: assert property (
		hdr_push && s_q.hidx >= 4'h8 |-> core_s.beat.data == 8'h00)
		else $error("service identifier not zero");

	a_first_sec_zero: assert property (
		s_q.st == ctsf_pkg::ST_IDLE ##1 s_q.st == ctsf_pkg::ST_HDR |-> s_q.sec == 8'h00)
		else $error("instance does not start at section zero");

	a_sec_step_one: assert property (
		push && core_s.beat.last && s_q.remain != 19'h00001
		|=> s_q.sec == $past(s_q.sec) + 8'h01 && s_q.hidx == 4'h0)
		else $error("section number did not step by one");

	a_inst_fields_hold: assert property (
		s_q.busy && $past(s_q.busy) |-> $stable(s_q.seq) && $stable(s_q.last_sec)
		&& $stable(s_q.ver_snap))
		else $error("instance field changed within instance");

	a_last_is_top: assert property (
		push && core_s.beat.last && s_q.remain == 19'h00001 |-> s_q.sec == s_q.last_sec
		##1 s_q.st == ctsf_pkg::ST_IDLE && s_q.in_left == 19'h00000)
		else $error("final section number mismatch");

	a_version_wrap: assert property (
		table_change_i |=> s_q.ver == $past(s_q.ver) + 5'h01)
		else $error("data version did not step modulo 32");

	a_payload_count: assert property (
		push && core_s.beat.last |-> s_q.pay_cnt + 11'h001 == s_q.pay_len
		&& s_q.pay_len <= 11'h400)
		else $error("payload count does not match length field");

	a_seq_byte: assert property (
		hdr_push && s_q.hidx == 4'h4 |-> core_s.beat.data == s_q.seq)
		else $error("sequence byte differs from instance number");

	a_len_low: assert property (
		hdr_push && s_q.hidx == 4'h2 |-> core_s.beat.data == 8'(s_q.pay_len + 11'h007))
		else $error("length low byte does not match payload size");

	a_hdr_step: assert property (
		hdr_push && s_q.hidx != 4'h9 |=> s_q.hidx == $past(s_q.hidx) + 4'h1)
		else $error("header bytes out of order");

	a_hdr_to_pay: assert property (
		hdr_push && s_q.hidx == 4'h9 |=> s_q.st == ctsf_pkg::ST_PAY && s_q.pay_cnt == 11'h000)
		else $error("payload does not follow the last header byte");

	a_take_gap: assert property (
		tbl_valid_i && tbl_ready_o |=> !tbl_ready_o)
		else $error("table input ready stayed high after a take");

	a_first_mark: assert property (
		push && core_s.beat.first |-> hdr_push && s_q.hidx == 4'h0)
		else $error("first mark on a byte other than the table identifier");

	a_start_loads: assert property (
		!s_q.busy && start_i && table_len_i != 19'h00000 && table_len_i <= 19'h40000
		|=> s_q.busy && s_q.sec == 8'h00 && s_q.seq == $past(seq_num_i))
		else $error("accepted start did not load the instance");

	c_single_section: cover property (
		push && core_s.beat.last && s_q.sec == 8'h00 && s_q.remain == 19'h00001);
	c_multi_section: cover property (
		push && core_s.beat.last && s_q.remain != 19'h00001);
	c_output_stall: cover property (
		sig_chan_valid_o && !sig_chan_ready_i ##1 sig_chan_valid_o && !sig_chan_ready_i);
	c_version_wrap: cover property (
		table_change_i && s_q.ver == 5'h1f);

endmodule
`default_nettype wire

// >>> logic/ctsf_pkg.sv
// Purpose: Shared constants and types of the compressed table section framer
// Assumes: Byte-wide streams, one clock domain
// Notes:   Header byte slots are listed in emission order
`default_nettype none
package ctsf_pkg;

	// Fixed header content
	localparam logic [7:0]  TABLE_ID      = 8'hec;
	localparam logic        SYNTAX_FLAG   = 1'b0;
	localparam logic        PRIVATE_FLAG  = 1'b1;
	localparam logic [1:0]  RSVD_BITS     = 2'b11;
	localparam logic [3:0]  PROTO_MAJOR   = 4'h1;
	localparam logic [3:0]  PROTO_MINOR   = 4'h0;
	localparam logic        CUR_NEXT      = 1'b1;
	localparam logic [15:0] SERVICE_ID    = 16'h0000;
	localparam logic [7:0]  FIRST_SECTION = 8'h00;

	// Bytes after the length field that precede the payload
	localparam logic [11:0] HDR_AFTER_LEN = 12'h007;

	// Header byte slots
	localparam logic [3:0] HB_TID    = 4'h0;
	localparam logic [3:0] HB_LEN_HI = 4'h1;
	localparam logic [3:0] HB_LEN_LO = 4'h2;
	localparam logic [3:0] HB_PROTO  = 4'h3;
	localparam logic [3:0] HB_SEQ    = 4'h4;
	localparam logic [3:0] HB_VER    = 4'h5;
	localparam logic [3:0] HB_SEC    = 4'h6;
	localparam logic [3:0] HB_LAST   = 4'h7;
	localparam logic [3:0] HB_SID_HI = 4'h8;
	localparam logic [3:0] HB_SID_LO = 4'h9;

	// Block sizing: 256 sections of 1024 bytes at most
	localparam int          BLK_W       = 10;
	localparam int          LEN_W       = 19;
	localparam logic [10:0] BLOCK_BYTES = 11'h400;
	localparam logic [18:0] MAX_LEN     = 19'h40000;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_HDR,
		ST_PAY
	} ctsf_fsm_t;

	typedef struct packed {
		logic       first;
		logic       last;
		logic [7:0] data;
	} ctsf_beat_t;

endpackage
`default_nettype wire

// >>> logic/ctsf_skid_buf.sv
// Purpose: Two-entry buffer in front of the signaling channel output
// Assumes: Receiver may hold ready low for any time
// Notes:   Ready is registered, so the second entry absorbs the late stall
`timescale 1ns/1ps
`default_nettype none
module ctsf_skid_buf (
	// Clock and reset
	input  wire logic         sys_clk_i,
	input  wire logic         rst_b_i,
	// Beats from the framer
	ctsf_stream_if.snk        in_s,
	// Beats to the receiver
	output logic              valid_o,
	output logic              first_o,
	output logic              last_o,
	output logic [7:0]        data_o,
	input  wire logic         ready_i
);

	typedef struct packed {
		logic                 out_v;
		ctsf_pkg::ctsf_beat_t out;
		logic                 skid_v;
		ctsf_pkg::ctsf_beat_t skid;
		logic                 rdy;
	} ctsf_buf_st_t;

	ctsf_buf_st_t s_q;
	ctsf_buf_st_t s_d;
	logic         acc;

	assign acc = in_s.valid & s_q.rdy;

	always_comb begin
		s_d = s_q;
		if (!s_q.out_v || ready_i) begin
			if (s_q.skid_v) begin
				s_d.out    = s_q.skid;
				s_d.out_v  = 1'b1;
				s_d.skid_v = 1'b0;
			end else begin
				s_d.out   = in_s.beat;
				s_d.out_v = acc;
			end
		end else if (acc) begin
			s_d.skid   = in_s.beat;
			s_d.skid_v = 1'b1;
		end
		s_d.rdy = ~s_d.skid_v;
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign in_s.ready = s_q.rdy;
	assign valid_o    = s_q.out_v;
	assign first_o    = s_q.out.first;
	assign last_o     = s_q.out.last;
	assign data_o     = s_q.out.data;

	a_buf_hold_data: assert property (
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		valid_o && !ready_i |=> valid_o && $stable(data_o) && $stable(last_o))
		else $error("output beat changed during stall");

	a_buf_no_overrun: assert property (
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_q.skid_v |-> !in_s.ready && valid_o)
		else $error("buffer accepted a beat while full");

	c_buf_full: cover property (
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_q.skid_v ##1 s_q.skid_v);

endmodule
`default_nettype wire

// >>> logic/ctsf_stream_if.sv
// Purpose: Section byte stream between framer core and output buffer
// Assumes: Valid/ready handshake, transfer when both high
// Notes:   Beat carries section start and end marks
`timescale 1ns/1ps
`default_nettype none
interface ctsf_stream_if;
	logic                 valid;
	logic                 ready;
	ctsf_pkg::ctsf_beat_t beat;

	modport src (output valid, output beat, input ready);
	modport snk (input valid, input beat, output ready);
endinterface
`default_nettype wire

// >>> verif/ctsf_rx_model.sv
// Purpose: Receiver model that filters sections and rebuilds the table
// Assumes: One clock; stall mode takes one beat in four
// Notes:   Keeps every byte seen, plus the rebuilt payload of the instance
`timescale 1ns/1ps
`default_nettype none
module ctsf_rx_model (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_b_i,
	// Section stream
	input  wire logic       valid_i,
	input  wire logic       first_i,
	input  wire logic       last_i,
	input  wire logic [7:0] data_i,
	output logic            ready_o,
	// Slow receiver mode
	input  wire logic       stall_i
);
	logic [7:0] byte_q[$];
	logic [1:0] flag_q[$];
	logic [7:0] pay_q[$];
	logic [7:0] hdr[10];
	logic [4:0] ver_q;
	logic [1:0] cnt_q;
	int         idx = 0;

	// Stall pattern backs up through the buffer into the table input
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q   <= 2'h0;
			ready_o <= 1'b0;
		end else begin
			cnt_q   <= cnt_q + 2'h1;
			ready_o <= !stall_i || (cnt_q == 2'h2);
		end
	end

	always @(posedge sys_clk_i) begin
		if (rst_b_i && valid_i && ready_o) begin
			byte_q.push_back(data_i);
			flag_q.push_back({first_i, last_i});
			idx = first_i ? 0 : idx + 1;
			if (idx < 10)
				hdr[idx] = data_i;
			else if (hdr[3][7:4] == 4'h1) begin
				// Restart on section zero or new version
				if (idx == 10 && (hdr[6] == 8'h00 || hdr[5][5:1] != ver_q))
					pay_q.delete();
				ver_q = hdr[5][5:1];
				pay_q.push_back(data_i);
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Purpose: Self-checking bench of the compressed table section framer
// Assumes: Receiver model on the output, bench feeds table bytes
// Notes:   Expected headers are built here from the field layout
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        sys_clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        start_i = 1'b0;
	logic [18:0] table_len_i = 19'h00000;
	logic [7:0]  seq_num_i = 8'h00;
	logic        table_change_i = 1'b0;
	logic        tbl_valid_i = 1'b0;
	logic [7:0]  tbl_data_i = 8'h00;
	logic        tbl_ready_o;
	logic        sig_chan_valid_o;
	logic        sig_chan_first_o;
	logic        sig_chan_last_o;
	logic [7:0]  sig_chan_data_o;
	logic        sig_chan_ready_i;
	logic        busy_o;
	logic [4:0]  data_version_o;
	logic        stall = 1'b0;
	logic [4:0]  exp_ver = 5'h00;
	int          miscompares = 0;
	int          checks_done = 0;

	always #5 sys_clk_i = ~sys_clk_i;

	ctsf_framer i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .start_i(start_i),
		.table_len_i(table_len_i), .seq_num_i(seq_num_i), .table_change_i(table_change_i),
		.tbl_valid_i(tbl_valid_i), .tbl_data_i(tbl_data_i), .tbl_ready_o(tbl_ready_o),
		.sig_chan_valid_o(sig_chan_valid_o), .sig_chan_first_o(sig_chan_first_o),
		.sig_chan_last_o(sig_chan_last_o), .sig_chan_data_o(sig_chan_data_o),
		.sig_chan_ready_i(sig_chan_ready_i), .busy_o(busy_o),
		.data_version_o(data_version_o));

	ctsf_rx_model i_rx (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .valid_i(sig_chan_valid_o),
		.first_i(sig_chan_first_o), .last_i(sig_chan_last_o), .data_i(sig_chan_data_o),
		.ready_o(sig_chan_ready_i), .stall_i(stall));

	task automatic close_out();
		if (miscompares == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic timed_out(input string what);
		miscompares++;
		$display("CHECK FAILED at %0t: %s timed out", $time, what);
		close_out();
	endtask

	function automatic logic [7:0] pat(input int i, input logic [7:0] seq);
		return 8'(i * 13) ^ seq;
	endfunction

	// Frames one table, then checks every header and the rebuilt payload
	task automatic run_table(input logic [18:0] len, input logic [7:0] seq, input logic stl);
		int          base;
		int          nsec;
		int          total;
		int          n;
		int          k;
		int          pl;
		logic [11:0] sl;
		base = i_rx.byte_q.size();
		nsec = (int'(len) + 1023) / 1024;
		total = int'(len) + 10 * nsec;
		@(posedge sys_clk_i);
		stall <= stl;
		start_i <= 1'b1;
		table_len_i <= len;
		seq_num_i <= seq;
		@(posedge sys_clk_i);
		// A second start and a version change while busy must not touch this instance
		seq_num_i <= ~seq;
		table_change_i <= 1'b1;
		tbl_valid_i <= 1'b1;
		for (int i = 0; i < int'(len); i++) begin
			if (i == 1) begin
				start_i <= 1'b0;
				table_change_i <= 1'b0;
			end
			tbl_data_i <= pat(i, seq);
			n = 0;
			do begin
				@(posedge sys_clk_i);
				n++;
			end while (tbl_ready_o !== 1'b1 && n < 2000);
			if (n >= 2000) timed_out("table byte");
		end
		tbl_valid_i <= 1'b0;
		n = 0;
		while (i_rx.byte_q.size() < base + total && n < 20000) begin
			@(posedge sys_clk_i);
			n++;
		end
		if (n >= 20000) timed_out("section drain");
		repeat (4) @(posedge sys_clk_i);
		chk(i_rx.byte_q.size(), base + total, "byte count");
		chk(busy_o, 1'b0, "busy after table");
		k = base;
		for (int s = 0; s < nsec; s++) begin
			pl = (int'(len) - 1024 * s > 1024) ? 1024 : int'(len) - 1024 * s;
			sl = 12'(7 + pl);
			chk(i_rx.flag_q[k], 2'b10, "first mark");
			chk(i_rx.byte_q[k], 8'hec, "table id");
			chk(i_rx.byte_q[k + 1], {4'h7, sl[11:8]}, "flags, length high");
			chk(i_rx.byte_q[k + 2], sl[7:0], "length low");
			chk(i_rx.byte_q[k + 3], 8'h10, "protocol version");
			chk(i_rx.byte_q[k + 4], seq, "sequence number");
			chk(i_rx.byte_q[k + 5], {2'b11, exp_ver, 1'b1}, "version byte");
			chk(i_rx.byte_q[k + 6], 8'(s), "section number");
			chk(i_rx.byte_q[k + 7], 8'(nsec - 1), "last section");
			chk({i_rx.byte_q[k + 8], i_rx.byte_q[k + 9]}, 16'h0000, "service id");
			chk(i_rx.flag_q[k + 9 + pl], 2'b01, "last mark");
			k += 10 + pl;
		end
		chk(i_rx.pay_q.size(), len, "payload size");
		for (int i = 0; i < int'(len); i++)
			chk(i_rx.pay_q[i], pat(i, seq), "payload byte");
		// The change given while busy applies from the next instance on
		exp_ver = exp_ver + 5'h01;
		chk(data_version_o, exp_ver, "version after busy change");
	endtask

	// Zero and oversize lengths start nothing
	task automatic sc_refused();
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk_i);
			start_i <= 1'b1;
			table_len_i <= i ? 19'h40001 : 19'h00000;
			@(posedge sys_clk_i);
			start_i <= 1'b0;
			repeat (4) @(posedge sys_clk_i);
			chk(busy_o, 1'b0, "bad length busy");
			chk(sig_chan_valid_o, 1'b0, "bad length output");
		end
	endtask

	// Thirty-three changes run the five-bit version once round, plus one
	task automatic sc_version();
		for (int i = 0; i < 33; i++) begin
			@(posedge sys_clk_i);
			table_change_i <= 1'b1;
			@(posedge sys_clk_i);
			table_change_i <= 1'b0;
			exp_ver = exp_ver + 5'h01;
		end
		repeat (2) @(posedge sys_clk_i);
		chk(data_version_o, exp_ver, "data version wrap");
	endtask

	initial begin
		repeat (8) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		@(posedge sys_clk_i);
		sc_refused();
		run_table(19'd5, 8'h5a, 1'b0);
		sc_version();
		run_table(19'd1027, 8'hc3, 1'b1);
		run_table(19'd1024, 8'h3c, 1'b0);
		close_out();
	end
endmodule
`default_nettype wire
